// >>> design/ext_bus_pins_defines.vh
// Constants for the external bus address, wait and port pin block.
// Included by ext_bus_pins.v; holds definitions only.
`ifndef EXT_BUS_PINS_DEFINES_VH
`define EXT_BUS_PINS_DEFINES_VH

// Bus-cycle state codes
`define ST_IDLE        3'h0
`define ST_ADDR        3'h1
`define ST_DATA1       3'h2
`define ST_WAIT        3'h3
`define ST_LAST        3'h4

// Field positions within the 22-bit external address
`define ADDR_W         22
`define ADDR_LOW_LSB   1
`define ADDR_LOW_MSB   4
`define ADDR_MID_LSB   5
`define ADDR_MID_MSB   12

// Reset values
`define ADDR_RESET     22'h000000
`define DIR_RESET_P11  4'hF
`define DIR_RESET_P12  1'h1
`define PORT_RESET_P11 4'h0
`define PORT_RESET_P12 1'h0
`define PORT_RESET_P10 8'h00
`define DIR_RESET_P10  8'hFF

// Bus clock divider: half period in core cycles
`define BUSCLK_HALF    1

`endif

// >>> design/ext_bus_pins.v
// External expansion bus pin logic: address groups on ports 10 and 11,
// wait input on port 12, bus clock output, reset and standby release.
// Assumes a bus requester that pulses a start with an address and a
// board that resolves pin levels from the active-low output enables.
`timescale 1ns/1ps
`include "ext_bus_pins_defines.vh"

// Behaviour
// RL1: In expansion mode port 10 pins drive address bits 5 to 12.
// RL2: In expansion mode port 11 low pins drive address bits 1 to 4.
// RL3: Address groups update at address-state rising edge; held when idle.
// RL4: Port 11 five bits, per-bit direction; top bit is input only.
// RL5: Lower four port 11 pins become address outputs when expanded.
// RL6: Port 12 single bit, own direction; alternate use is wait input.
// RL7: Wait sampled on falling edge in first data or wait state.
// RL8: Internal bus clock is driven out on a dedicated pin.
// RL9: Reset is asynchronous and overrides every other operation.
// RL10: Reset also releases any standby state.
// RL11: Address in first state; data in following data, wait, last.
// RL12: Mode register settings choose port or bus use of shared pins.
// RL13: Low wait inserts another wait state; high lets cycle finish.
module ext_bus_pins
#(
  // Core cycles per bus clock half period, 1 to 256
  parameter BUS_HALF = `BUSCLK_HALF
)
(
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        resetn_in,
  // Bus requester
  input  wire        cycle_start_in,
  input  wire [21:0] cycle_addr_in,
  output reg         cycle_busy_out,
  output reg         cycle_done_out,
  // Mode, direction and port data settings
  input  wire        expand_mid_in,
  input  wire        expand_low_in,
  input  wire        wait_enable_in,
  input  wire [3:0]  port11_direction_in,
  input  wire        port12_direction_in,
  input  wire [7:0]  port10_data_in,
  input  wire [3:0]  port11_data_in,
  input  wire        port12_data_in,
  // Standby control
  input  wire        standby_enter_in,
  output reg         standby_out,
  // Port 10 pins
  output reg  [7:0]  port10_pins_out,
  output reg  [7:0]  port10_pins_oe_n_out,
  // Port 11 pins
  input  wire [4:0]  port11_pins_in,
  output reg  [3:0]  port11_pins_out,
  output reg  [3:0]  port11_pins_oe_n_out,
  output reg  [4:0]  port11_read_out,
  // Port 12 pin
  input  wire        port12_pin_in,
  output reg         port12_pin_out,
  output reg         port12_pin_oe_n_out,
  output reg         port12_read_out,
  // Bus clock
  output reg         bus_clock_output
);

  // ******************************************************************
  // Bus clock
  // ******************************************************************
  // The bus clock toggles after BUS_HALF core cycles. Sequencer and
  // wait sampler run on the core clock and use one-cycle strobes for
  // the bus edges, so no logic is clocked by a derived clock.
  // Limitation: the divider is 8 bits wide.
  reg  [7:0]  div_q;
  reg  [7:0]  div_d;
  reg         busclk_q;
  reg         busclk_d;
  wire        toggle_now;
  wire        rise_now;
  wire        fall_now;

  // Last count value of one half period
  function [7:0] half_last;
    input integer half;
    begin
      half_last = half[7:0] - 8'h01;
    end
  endfunction

  assign toggle_now = (div_q == half_last(BUS_HALF));
  assign rise_now   = toggle_now & ~busclk_q;
  assign fall_now   = toggle_now & busclk_q;

  always @*
  begin
    div_d    = div_q + 8'h01;
    busclk_d = busclk_q;
    if (toggle_now)
    begin
      div_d    = 8'h00;
      busclk_d = ~busclk_q;
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_q    <= 8'h00;
      busclk_q <= 1'h0;
    end
    else
    begin
      div_q    <= div_d;
      busclk_q <= busclk_d;
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bus_clock_output <= 1'h0;
    else
      bus_clock_output <= busclk_d; // RL8
  end

  // ******************************************************************
  // Bus-cycle sequencer
  // ******************************************************************
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [21:0] addr_q;
  reg  [21:0] addr_d;
  reg  [21:0] pend_addr_q;
  reg         pend_q;
  reg         wait_low_q;
  wire        wait_pin;

  // Wait comes from the port 12 pin only in its alternate use
  assign wait_pin = (wait_enable_in & port12_direction_in) ?
                    port12_pin_in : 1'h1; // RL6

  always @*
  begin
    state_d = state_q;
    addr_d  = addr_q;
    // States advance only on a rising bus edge
    if (rise_now)
    begin
      case (state_q)
        `ST_IDLE:
        begin
          if (pend_q)
          begin
            state_d = `ST_ADDR;
            addr_d  = pend_addr_q; // RL3 RL11
          end
        end
        `ST_ADDR:
          state_d = `ST_DATA1; // RL11
        `ST_DATA1,
        `ST_WAIT:
          state_d = wait_low_q ? `ST_WAIT : `ST_LAST; // RL13
        `ST_LAST:
          state_d = `ST_IDLE;
        default:
          state_d = `ST_IDLE;
      endcase
    end
  end

  // Address holds between cycles because only ST_IDLE exit loads it
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= `ST_IDLE; // RL9
      addr_q  <= `ADDR_RESET;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d; // RL3
    end
  end

  // One request is held; a start while it pends is dropped
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend_q      <= 1'h0;
      pend_addr_q <= `ADDR_RESET;
    end
    else if (cycle_start_in && !pend_q)
    begin
      pend_q      <= 1'h1;
      pend_addr_q <= cycle_addr_in;
    end
    else if (rise_now && state_q == `ST_IDLE)
      pend_q <= 1'h0;
  end

  // First data state or an inserted wait state
  function in_data;
    input [2:0] st;
    begin
      in_data = (st == `ST_DATA1) || (st == `ST_WAIT);
    end
  endfunction

  // Sample on falling bus edge, only in first data or wait state
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_low_q <= 1'h0;
    else if (fall_now && in_data(state_q))
      wait_low_q <= ~wait_pin; // RL7 RL13
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cycle_busy_out <= 1'h0;
      cycle_done_out <= 1'h0;
    end
    else
    begin
      // Busy covers the start edge itself so a second start waits
      cycle_busy_out <= (state_d != `ST_IDLE) | pend_q | cycle_start_in;
      cycle_done_out <= rise_now && (state_q == `ST_LAST);
    end
  end

  // ******************************************************************
  // Standby
  // ******************************************************************
  // Reset is the only release modelled here; entry is from the core.
  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      standby_out <= 1'h0; // RL10
    // One entry pulse parks the core until the next reset
    else if (standby_enter_in)
      standby_out <= 1'h1;
  end

  // ******************************************************************
  // Pin multiplexing
  // ******************************************************************
  // Next pin values; every pin output is registered below
  reg  [7:0]  p10_d;
  reg  [7:0]  p10_oe_n_d;
  reg  [3:0]  p11_d;
  reg  [3:0]  p11_oe_n_d;
  reg         p12_oe_n_d;

  always @*
  begin
    p10_d      = port10_data_in;
    p10_oe_n_d = `DIR_RESET_P10;
    p11_d      = port11_data_in;
    p11_oe_n_d = port11_direction_in; // RL4
    if (expand_mid_in) // RL12
    begin
      p10_d      = addr_d[`ADDR_MID_MSB:`ADDR_MID_LSB]; // RL1
      p10_oe_n_d = 8'h00;
    end
    if (expand_low_in) // RL12
    begin
      p11_d      = addr_d[`ADDR_LOW_MSB:`ADDR_LOW_LSB]; // RL2
      p11_oe_n_d = 4'h0; // RL5
    end
    // In wait use the pin stays released so the far side can pull it
    p12_oe_n_d = port12_direction_in | wait_enable_in; // RL6
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      port10_pins_out      <= `PORT_RESET_P10;
      port10_pins_oe_n_out <= `DIR_RESET_P10;
      port11_pins_out      <= `PORT_RESET_P11;
      port11_pins_oe_n_out <= `DIR_RESET_P11;
      port11_read_out      <= 5'h00;
      port12_pin_out       <= `PORT_RESET_P12;
      port12_pin_oe_n_out  <= `DIR_RESET_P12;
      port12_read_out      <= 1'h0;
    end
    else
    begin
      port10_pins_out      <= p10_d;
      port10_pins_oe_n_out <= p10_oe_n_d;
      port11_pins_out      <= p11_d;
      port11_pins_oe_n_out <= p11_oe_n_d;
      // Top bit is the subclock crystal input, never driven
      port11_read_out      <= port11_pins_in; // RL4
      port12_pin_out       <= port12_data_in;
      port12_pin_oe_n_out  <= p12_oe_n_d;
      port12_read_out      <= port12_pin_in;
    end
  end

endmodule // ext_bus_pins

// >>> tb/ext_bus_pins_assertions.sv
// Checker for the bus pin block, bound to its top-level ports.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module ext_bus_pins_checker
(
  // Watched ports
  input wire       core_clk_in, resetn_in, cycle_start_in,
  input wire       cycle_busy_out, cycle_done_out, standby_out,
  input wire       expand_mid_in, expand_low_in, wait_enable_in,
  input wire       port12_pin_oe_n_out, bus_clock_output,
  input wire [7:0] port10_pins_out, port10_pins_oe_n_out,
  input wire [3:0] port11_pins_out, port11_pins_oe_n_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Three idle cycles so a mode switch has settled
  sequence s_idle3;
    (expand_mid_in && expand_low_in && !cycle_busy_out)[*3];
  endsequence
  a_mid_drive: assert property (expand_mid_in[*2] |->
    port10_pins_oe_n_out == 8'h00) else $error("port10 idle");
  a_low_drive: assert property (expand_low_in[*2] |->
    port11_pins_oe_n_out == 4'h0) else $error("port11 idle");
  a_port_mode: assert property ((!expand_mid_in)[*2] |->
    port10_pins_oe_n_out == 8'hFF) else $error("port10 driven");
  a_addr_hold: assert property (s_idle3 |->
    $stable(port10_pins_out) && $stable(port11_pins_out))
    else $error("address moved while idle");
  a_wait_in: assert property (wait_enable_in[*2] |->
    port12_pin_oe_n_out) else $error("wait pin driven");
  a_done_one: assert property (cycle_done_out |=>
    !cycle_done_out && !cycle_busy_out) else $error("done too long");
  a_take_req: assert property (cycle_start_in && !cycle_busy_out
    |=> cycle_busy_out) else $error("start not taken");
  a_min_len: assert property ($rose(cycle_busy_out) && !wait_enable_in
    |-> ##[6:10] cycle_done_out) else $error("cycle length");
  a_clk_out: assert property (bus_clock_output |=>
    !bus_clock_output) else $error("bus clock stuck");
  a_standby_on: assert property (standby_out |=> standby_out)
    else $error("standby left without reset");
endmodule // ext_bus_pins_checker
bind ext_bus_pins ext_bus_pins_checker chk (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .cycle_start_in(cycle_start_in), .cycle_busy_out(cycle_busy_out),
  .cycle_done_out(cycle_done_out), .standby_out(standby_out),
  .expand_mid_in(expand_mid_in), .expand_low_in(expand_low_in),
  .wait_enable_in(wait_enable_in),
  .port12_pin_oe_n_out(port12_pin_oe_n_out),
  .bus_clock_output(bus_clock_output),
  .port10_pins_out(port10_pins_out),
  .port10_pins_oe_n_out(port10_pins_oe_n_out),
  .port11_pins_out(port11_pins_out),
  .port11_pins_oe_n_out(port11_pins_oe_n_out));

// >>> tb/wait_device_model.sv
// Slow external device: holds the wait pin low for a set count.
// Assumes the bus clock and busy flag of the block under test.
`timescale 1ns/1ps
module wait_device_model
(
  // Bus side
  input  wire       bus_clk_in,
  input  wire       busy_in,
  input  wire [3:0] waits_in,
  output wire       wait_n_out
);
  reg [3:0] falls_q = 4'h0;
  reg       armed_q = 1'b0;
  // Pin goes low on a rising edge once armed and is released on a falling edge, so it is valid at the next falling edge
  always @(posedge bus_clk_in) armed_q <= busy_in;
  always @(negedge bus_clk_in or negedge busy_in)
    if (!busy_in)
      falls_q <= 4'h0;
    else if (armed_q)
      falls_q <= falls_q + 4'h1;
  // Released pin is pulled up on the board
  assign wait_n_out = !(busy_in && armed_q && falls_q < waits_in + 4'h1);
endmodule // wait_device_model

// >>> tb/tb_top.sv
// Self-checking bench for the bus pin block.
// Assumes the partner model drives the wait pin when enabled.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
  $display("Error %s exp %h seen %h", n, e, s); end end
module tb_top;
  reg        core_clk_in = 0, resetn_in = 0, cycle_start_in = 0;
  reg        expand_mid_in = 0, expand_low_in = 0, wait_enable_in = 0;
  reg        port12_direction_in = 1, port12_data_in = 0;
  reg        standby_enter_in = 0, ext12 = 1;
  reg [21:0] cycle_addr_in = 22'h000000;
  reg [7:0]  port10_data_in = 8'h00;
  reg [3:0]  port11_direction_in = 4'hF, port11_data_in = 4'h0, waits = 4'h0;
  reg [4:0]  ext11 = 5'h00;
  wire       cycle_busy_out, cycle_done_out, standby_out, bus_clock_output;
  wire       port12_pin_out, port12_pin_oe_n_out, port12_read_out;
  wire       port12_pin_in, wait_n;
  wire [7:0] port10_pins_out, port10_pins_oe_n_out;
  wire [3:0] port11_pins_out, port11_pins_oe_n_out;
  wire [4:0] port11_read_out, port11_pins_in;
  int        num_errors = 0, checked = 0;
  // Wire levels from every driver's enable
  assign port11_pins_in = {ext11[4], (port11_pins_oe_n_out & ext11[3:0]) |
                           (~port11_pins_oe_n_out & port11_pins_out)};
  assign port12_pin_in = port12_pin_oe_n_out ?
                         (wait_enable_in ? wait_n : ext12) : port12_pin_out;
  ext_bus_pins dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .cycle_start_in(cycle_start_in), .cycle_addr_in(cycle_addr_in),
    .cycle_busy_out(cycle_busy_out), .cycle_done_out(cycle_done_out),
    .expand_mid_in(expand_mid_in), .expand_low_in(expand_low_in),
    .wait_enable_in(wait_enable_in),
    .port11_direction_in(port11_direction_in),
    .port12_direction_in(port12_direction_in),
    .port10_data_in(port10_data_in), .port11_data_in(port11_data_in),
    .port12_data_in(port12_data_in), .standby_enter_in(standby_enter_in),
    .standby_out(standby_out), .port10_pins_out(port10_pins_out),
    .port10_pins_oe_n_out(port10_pins_oe_n_out),
    .port11_pins_in(port11_pins_in), .port11_pins_out(port11_pins_out),
    .port11_pins_oe_n_out(port11_pins_oe_n_out),
    .port11_read_out(port11_read_out), .port12_pin_in(port12_pin_in),
    .port12_pin_out(port12_pin_out),
    .port12_pin_oe_n_out(port12_pin_oe_n_out),
    .port12_read_out(port12_read_out),
    .bus_clock_output(bus_clock_output));
  wait_device_model dev (.bus_clk_in(bus_clock_output),
    .busy_in(cycle_busy_out), .waits_in(waits), .wait_n_out(wait_n));
  initial forever #12.5 core_clk_in = ~core_clk_in;
  task close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task t_cycle(input [21:0] a, input [3:0] w);
    int n;
    @(negedge core_clk_in);
    waits = w;
    wait_enable_in = (w != 4'h0);
    cycle_addr_in = a;
    cycle_start_in = 1;
    @(negedge core_clk_in) cycle_start_in = 0;
    for (n = 1; n < 40 && cycle_done_out !== 1'b1; n++) @(negedge core_clk_in);
    `CHK("latency", 1'b1, n - 1 >= 7 + 2 * w && n - 1 <= 8 + 2 * w)
    if (n == 40)
      close_out;
    repeat (3) @(negedge core_clk_in);
    `CHK("addr mid", a[12:5], port10_pins_out)
    `CHK("addr low", a[4:1], port11_pins_out)
  endtask
  task t_port;
    @(negedge core_clk_in);
    {expand_mid_in, expand_low_in, wait_enable_in, port12_direction_in} = 0;
    port11_direction_in = 4'hA;
    port11_data_in = 4'h5;
    port12_data_in = 1;
    ext11 = 5'h10;
    repeat (3) @(negedge core_clk_in);
    `CHK("p11 oe", 4'hA, port11_pins_oe_n_out)
    `CHK("p11 read", 5'h15, port11_read_out)
    `CHK("p12 oe", 1'b0, port12_pin_oe_n_out)
    `CHK("p12 read", 1'b1, port12_read_out)
    `CHK("p10 oe", 8'hFF, port10_pins_oe_n_out)
    {expand_mid_in, expand_low_in, port12_direction_in} = 3'h7;
    port11_direction_in = 4'hF;
  endtask
  task t_reset;
    resetn_in = 0;
    #1;
    `CHK("p10 oe", 8'hFF, port10_pins_oe_n_out)
    `CHK("p11 oe", 4'hF, port11_pins_oe_n_out)
    `CHK("busy", 1'b0, cycle_busy_out)
    `CHK("bus clk", 1'b0, bus_clock_output)
    `CHK("standby", 1'b0, standby_out)
    repeat (2) @(negedge core_clk_in);
    resetn_in = 1;
  endtask
  task t_standby;
    @(negedge core_clk_in) standby_enter_in = 1;
    @(negedge core_clk_in) standby_enter_in = 0;
    repeat (2) @(negedge core_clk_in);
    `CHK("standby", 1'b1, standby_out)
    t_reset;
  endtask
  initial
  begin
    repeat (10) @(negedge core_clk_in);
    resetn_in = 1;
    {expand_mid_in, expand_low_in} = 2'h3;
    t_cycle(22'h3FFFFE, 4'h0);
    t_cycle(22'h00155A, 4'h1);
    t_cycle(22'h002AA4, 4'h3);
    t_port;
    t_cycle(22'h000020, 4'h2);
    t_standby;
    t_cycle(22'h001FE0, 4'h0);
    close_out;
  end
endmodule // tb_top
